// File: cbsc_ctrl.sv
// system control register low half, bits 21 to 0, for two functions
//
// Behaviour
// R1 - per socket bit 21 set disables supply protection for 16-bit cards
// R2 - bit 20 set floats card address lines A25-A22 on 16-bit cards
// R3 - bit 15 set, the default, lets downstream memory reads burst
// R4 - bit 14 set lets upstream memory reads burst; default off
// R5 - per socket bit 13 sets on card access, clears when read
// R6 - reserved bit 12 reads as one
// R7 - software keeps reserved bits 19-16 and bit 3 at defaults
// R8 - reserved bit 7 reads as zero
// R9 - bit 11 busy during power stream and its following delay
// R10 - bit 10 set after power-up stream until settling delay expires
// R11 - bit 9 set after power-down stream until delay expires
// R12 - per socket bit 8 is one while card interrogation runs
// R13 - bit 6 stops idle clockless 32-bit card state machine clock
// R14 - bit 5, shared, locks identification registers read-only when one
// R15 - bit 4 set reports card bus data parity errors on SERR
// R16 - bit 2 selects legacy supply: zero 3.3 V, one 5 V
// R17 - bit 1 set forbids stopping card or host clock via CLKRUN
// R18 - bit 0 chooses shared ring/PME pin or PME only
// R19 - global bits live only in function 0; reserved bits 19-16 and 3 are written and read from both functions
// R20 - register answers at configuration offset 80h in both functions
// R21 - writes to read-only and reserved-read positions are ignored
`timescale 1ns/1ps
`default_nettype none

module cbsc_ctrl
   import cbsc_pkg::*;
#(
   parameter int SOCKETS = 2
)
(
   input  wire logic               clk_sys,
   input  wire logic               rst,
   input  wire cbsc_cfg_req_t      cfg_req,
   output logic                    cfg_hit,
   output logic [31:0]             cfg_rdata,
   input  wire logic [SOCKETS-1:0] card_access,
   input  wire logic [SOCKETS-1:0] probe_running,
   input  wire cbsc_pwr_evt_t      pwr_evt,
   input  wire logic [SOCKETS-1:0] card_is_32bit,
   input  wire logic [SOCKETS-1:0] card_idle,
   input  wire logic [SOCKETS-1:0] card_clk_running,
   input  wire logic               card_parity_err,
   input  wire logic               clkrun_stop_req,
   input  wire logic               ring_enable,
   input  wire logic               ring_request,
   input  wire logic               pme_request,
   output logic [SOCKETS-1:0]      supply_protect_disable,
   output logic [SOCKETS-1:0]      reduced_video_addr_float,
   output logic                    read_burst_down_enable,
   output logic                    read_burst_up_enable,
   output logic [SOCKETS-1:0]      sm_clock_enable,
   output logic                    ident_write_lock,
   output logic                    syserr_from_card_parity,
   output logic [SOCKETS-1:0]      legacy_supply_select,
   output logic                    clkrun_stop_allow,
   output logic                    ring_indicate_output
);

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   // true when the access targets this register
   function automatic logic reg_hit(input logic [7:0] addr);
      reg_hit = (addr[7:2] == CBSC_OFFSET[7:2]);
   endfunction : reg_hit

   // true when byte lane holding bit pos is enabled
   function automatic logic lane_on(input logic [3:0] be, input int pos);
      lane_on = be[pos / 8];
   endfunction : lane_on

   logic       hit;
   logic       wr_hit;
   logic       rd_hit;
   logic       sock;
   logic       fn0_wr;
   logic [3:0] be;
   logic [31:0] wd;

   assign hit    = reg_hit(cfg_req.addr);                 // R20
   assign wr_hit = hit && cfg_req.wr;
   assign rd_hit = hit && cfg_req.rd;
   assign sock   = cfg_req.func;
   assign fn0_wr = wr_hit && (cfg_req.func == 1'b0);      // R19
   assign be     = cfg_req.be;
   assign wd     = cfg_req.wdata;
   assign cfg_hit = hit;

   ////////////////////////////////////////////////////////////////////////
   // global fields, writable only from function 0 except the reserved positions

   logic       burst_dn;
   logic       burst_up;
   logic       id_lock;
   logic       par_serr;
   logic       clk_keep;
   logic [3:0] rsvd_hi;
   logic       rsvd_lo;

   // read burst controls, both in byte lane 1
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         burst_dn <= CBSC_RST_BURST_DN;
         burst_up <= CBSC_RST_BURST_UP;
      end
      else if (fn0_wr && lane_on(be, CBSC_POS_BURST_DN))  // R19
      begin
         burst_dn <= wd[CBSC_POS_BURST_DN];                // R3
         burst_up <= wd[CBSC_POS_BURST_UP];                // R4
      end
   end

   // identification registers write lock
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         id_lock <= CBSC_RST_ID_LOCK;
      else if (fn0_wr && lane_on(be, CBSC_POS_ID_LOCK))   // R19
         id_lock <= wd[CBSC_POS_ID_LOCK];                  // R14
   end

   // card parity reporting enable
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         par_serr <= CBSC_RST_OTHER;
      else if (fn0_wr && lane_on(be, CBSC_POS_PAR_SERR))
         par_serr <= wd[CBSC_POS_PAR_SERR];                // R15
   end

   // clock stop inhibit
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         clk_keep <= CBSC_RST_OTHER;
      else if (fn0_wr && lane_on(be, CBSC_POS_CLK_KEEP))
         clk_keep <= wd[CBSC_POS_CLK_KEEP];                // R17
   end

   // writable reserved positions, kept as written (software keeps defaults)
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rsvd_hi <= CBSC_RST_RSVD_HI;
         rsvd_lo <= CBSC_RST_OTHER;
      end
      else if (wr_hit)
      begin
         if (lane_on(be, CBSC_POS_RSVD_HI))
            rsvd_hi <= wd[CBSC_POS_RSVD_HI +: 4];          // R7
         if (lane_on(be, CBSC_POS_RSVD_LO))
            rsvd_lo <= wd[CBSC_POS_RSVD_LO];               // R7
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per socket fields, one copy per function

   logic [SOCKETS-1:0] prot_dis;
   logic [SOCKETS-1:0] zv_float;
   logic [SOCKETS-1:0] clk_gate;
   logic [SOCKETS-1:0] leg_sup;
   logic [SOCKETS-1:0] pin_sel;
   logic [SOCKETS-1:0] activity;

   genvar g;
   generate
      for (g = 0; g < SOCKETS; g = g + 1)
      begin : g_sock
         logic sel;
         assign sel = wr_hit && (int'(sock) == g);

         // supply protection and reduced video address controls
         always_ff @(posedge clk_sys)
         begin
            if (rst)
            begin
               prot_dis[g] <= CBSC_RST_OTHER;
               zv_float[g] <= CBSC_RST_OTHER;
            end
            else if (sel && lane_on(be, CBSC_POS_PROT_DIS))
            begin
               prot_dis[g] <= wd[CBSC_POS_PROT_DIS];       // R1
               zv_float[g] <= wd[CBSC_POS_ZV_FLOAT];       // R2
            end
         end

         // idle card clock gating enable
         always_ff @(posedge clk_sys)
         begin
            if (rst)
               clk_gate[g] <= CBSC_RST_CLK_GATE;
            else if (sel && lane_on(be, CBSC_POS_CLK_GATE))
               clk_gate[g] <= wd[CBSC_POS_CLK_GATE];       // R13
         end

         // legacy supply voltage select
         always_ff @(posedge clk_sys)
         begin
            if (rst)
               leg_sup[g] <= CBSC_RST_OTHER;
            else if (sel && lane_on(be, CBSC_POS_LEG_SUPPLY))
               leg_sup[g] <= wd[CBSC_POS_LEG_SUPPLY];      // R16
         end

         // ring and power event pin mode
         always_ff @(posedge clk_sys)
         begin
            if (rst)
               pin_sel[g] <= CBSC_RST_OTHER;
            else if (sel && lane_on(be, CBSC_POS_PIN_SEL))
               pin_sel[g] <= wd[CBSC_POS_PIN_SEL];         // R18
         end

         // activity flag: set wins over the clear by read
         always_ff @(posedge clk_sys)
         begin
            if (rst)
               activity[g] <= 1'b0;
            else if (card_access[g])
               activity[g] <= 1'b1;                        // R5
            else if (rd_hit && int'(sock) == g &&
                     lane_on(be, CBSC_POS_ACTIVITY))
               activity[g] <= 1'b0;                        // R5
         end

         // state machine clock gate for idle clockless 32-bit cards
         assign sm_clock_enable[g] = !(clk_gate[g] && card_is_32bit[g] &&
                                      card_idle[g] &&
                                      !card_clk_running[g]);   // R13
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // power switch progress tracking

   logic stream_busy;
   logic up_busy;
   logic down_busy;

   cbsc_pwr_track u_pwr
   (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .evt         (pwr_evt),
      .stream_busy (stream_busy),
      .up_busy     (up_busy),
      .down_busy   (down_busy)
   );

   ////////////////////////////////////////////////////////////////////////
   // read data, registered; global bits other than the reserved positions read zero in function 1

   logic [31:0] next_rdata;
   logic        f0;

   always_comb
   begin
      f0 = (sock == 1'b0);
      next_rdata = 32'h0000_0000;                           // R8
      next_rdata[CBSC_POS_PROT_DIS]   = prot_dis[sock];
      next_rdata[CBSC_POS_ZV_FLOAT]   = zv_float[sock];
      next_rdata[CBSC_POS_RSVD_HI +: 4] = rsvd_hi;
      next_rdata[CBSC_POS_BURST_DN]   = f0 && burst_dn;     // R19
      next_rdata[CBSC_POS_BURST_UP]   = f0 && burst_up;
      next_rdata[CBSC_POS_ACTIVITY]   = activity[sock];
      next_rdata[CBSC_POS_RSVD_ONE]   = CBSC_RSVD_ONE_VAL;  // R6
      next_rdata[CBSC_POS_STREAM]     = f0 && stream_busy;  // R9
      next_rdata[CBSC_POS_DLY_UP]     = f0 && up_busy;      // R10
      next_rdata[CBSC_POS_DLY_DN]     = f0 && down_busy;    // R11
      next_rdata[CBSC_POS_PROBE]      = probe_running[sock]; // R12
      next_rdata[CBSC_POS_CLK_GATE]   = clk_gate[sock];
      next_rdata[CBSC_POS_ID_LOCK]    = f0 && id_lock;
      next_rdata[CBSC_POS_PAR_SERR]   = f0 && par_serr;
      next_rdata[CBSC_POS_RSVD_LO]    = rsvd_lo;
      next_rdata[CBSC_POS_LEG_SUPPLY] = leg_sup[sock];
      next_rdata[CBSC_POS_CLK_KEEP]   = f0 && clk_keep;
      next_rdata[CBSC_POS_PIN_SEL]    = pin_sel[sock];
   end

   // read data captured on a read hit; status and constant bits take no write
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         cfg_rdata <= 32'h0000_0000;
      else if (rd_hit)
         cfg_rdata <= next_rdata;                           // R21
   end

   ////////////////////////////////////////////////////////////////////////
   // control outputs from the stored fields

   assign supply_protect_disable   = prot_dis;           // R1
   assign reduced_video_addr_float = zv_float;           // R2
   assign read_burst_down_enable   = burst_dn;           // R3
   assign read_burst_up_enable     = burst_up;           // R4
   assign ident_write_lock         = id_lock;            // R14
   assign legacy_supply_select     = leg_sup;            // R16

   // parity reporting onto the system error line
   assign syserr_from_card_parity = par_serr && card_parity_err; // R15

   // clock stop permitted only when not kept running
   assign clkrun_stop_allow = clkrun_stop_req && !clk_keep;      // R17

   // shared ring/PME pin, mode from socket 0 copy
   always_comb
   begin
      if (pin_sel[0])
         ring_indicate_output = pme_request;                      // R18
      else if (ring_enable)
         ring_indicate_output = ring_request;                     // R18
      else
         ring_indicate_output = pme_request;
   end

endmodule : cbsc_ctrl

`default_nettype wire

// File: cbsc_ctrl_sva.sv
// checker of the system control low half register ports
`timescale 1ns/1ps
`default_nettype none

module cbsc_ctrl_sva
   import cbsc_pkg::*;
#(
   parameter int SOCKETS = 2
)
(
   input wire logic               clk_sys,
   input wire logic               rst,
   input wire cbsc_cfg_req_t      cfg_req,
   input wire logic               cfg_hit,
   input wire logic [31:0]        cfg_rdata,
   input wire logic [SOCKETS-1:0] card_is_32bit,
   input wire logic [SOCKETS-1:0] card_idle,
   input wire logic [SOCKETS-1:0] card_clk_running,
   input wire logic               card_parity_err,
   input wire logic               clkrun_stop_req,
   input wire logic               ring_enable,
   input wire logic               pme_request,
   input wire logic [SOCKETS-1:0] supply_protect_disable,
   input wire logic [SOCKETS-1:0] reduced_video_addr_float,
   input wire logic               read_burst_down_enable,
   input wire logic               read_burst_up_enable,
   input wire logic [SOCKETS-1:0] sm_clock_enable,
   input wire logic               ident_write_lock,
   input wire logic               syserr_from_card_parity,
   input wire logic [SOCKETS-1:0] legacy_supply_select,
   input wire logic               clkrun_stop_allow,
   input wire logic               ring_indicate_output
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // request decode at the register address
   logic at_reg;
   logic wr_hit;
   logic rd_hit;
   logic wr0;
   assign at_reg = (cfg_req.addr[7:2] == 6'h20);
   assign wr_hit = cfg_req.wr && at_reg;
   assign rd_hit = cfg_req.rd && at_reg;
   assign wr0    = wr_hit && !cfg_req.func;

   ////////////////////////////////////////////////////////////////////////
   // properties
   property p_hit;
      cfg_hit == at_reg;
   endproperty
   a_hit: assert property (p_hit) else $error("hit decode wrong");
   property p_dn;
      wr0 && cfg_req.be[1] |=>
         read_burst_down_enable == $past(cfg_req.wdata[15]);
   endproperty
   a_dn: assert property (p_dn) else $error("burst down wrong");
   property p_up;
      wr0 && cfg_req.be[1] |=>
         read_burst_up_enable == $past(cfg_req.wdata[14]);
   endproperty
   a_up: assert property (p_up) else $error("burst up wrong");
   property p_lock;
      wr0 && cfg_req.be[0] |=> ident_write_lock == $past(cfg_req.wdata[5]);
   endproperty
   a_lock: assert property (p_lock) else $error("ident lock wrong");
   property p_glob;
      wr_hit && cfg_req.func |=> $stable(read_burst_down_enable)
         && $stable(read_burst_up_enable) && $stable(ident_write_lock);
   endproperty
   a_glob: assert property (p_glob) else $error("global bit moved");
   property p_serr;
      wr0 && cfg_req.be[0] |=> syserr_from_card_parity ==
         (card_parity_err && $past(cfg_req.wdata[4]));
   endproperty
   a_serr: assert property (p_serr) else $error("parity report wrong");
   property p_clk;
      wr0 && cfg_req.be[0] |=> clkrun_stop_allow ==
         (clkrun_stop_req && !$past(cfg_req.wdata[1]));
   endproperty
   a_clk: assert property (p_clk) else $error("clock stop wrong");
   property p_sock;
      wr_hit && cfg_req.be[2] |=>
         supply_protect_disable[$past(cfg_req.func)] == $past(cfg_req.wdata[21])
         && reduced_video_addr_float[$past(cfg_req.func)] ==
         $past(cfg_req.wdata[20]);
   endproperty
   a_sock: assert property (p_sock) else $error("socket bit wrong");
   property p_leg;
      wr_hit && cfg_req.be[0] |=>
         legacy_supply_select[$past(cfg_req.func)] == $past(cfg_req.wdata[2]);
   endproperty
   a_leg: assert property (p_leg) else $error("supply select wrong");
   property p_smclk;
      card_clk_running[0] || !card_idle[0] || !card_is_32bit[0]
         |-> sm_clock_enable[0];
   endproperty
   a_smclk: assert property (p_smclk) else $error("clock gated wrongly");
   property p_ring;
      !ring_enable |-> ring_indicate_output == pme_request;
   endproperty
   a_ring: assert property (p_ring) else $error("pin mux wrong");
   property p_rsvd;
      rd_hit |=> cfg_rdata[12] && !cfg_rdata[7];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit wrong");
   property p_fn1;
      rd_hit && cfg_req.func |=> cfg_rdata[15:14] == 2'h0
         && cfg_rdata[11:9] == 3'h0 && cfg_rdata[5:4] == 2'h0 && !cfg_rdata[1];
   endproperty
   a_fn1: assert property (p_fn1) else $error("global seen in fn1");
endmodule : cbsc_ctrl_sva

bind cbsc_ctrl cbsc_ctrl_sva #(.SOCKETS(SOCKETS)) u_sva (
   .clk_sys(clk_sys), .rst(rst), .cfg_req(cfg_req), .cfg_hit(cfg_hit),
   .cfg_rdata(cfg_rdata), .card_is_32bit(card_is_32bit),
   .card_idle(card_idle), .card_clk_running(card_clk_running),
   .card_parity_err(card_parity_err), .clkrun_stop_req(clkrun_stop_req),
   .ring_enable(ring_enable), .pme_request(pme_request),
   .supply_protect_disable(supply_protect_disable),
   .reduced_video_addr_float(reduced_video_addr_float),
   .read_burst_down_enable(read_burst_down_enable),
   .read_burst_up_enable(read_burst_up_enable),
   .sm_clock_enable(sm_clock_enable), .ident_write_lock(ident_write_lock),
   .syserr_from_card_parity(syserr_from_card_parity),
   .legacy_supply_select(legacy_supply_select),
   .clkrun_stop_allow(clkrun_stop_allow),
   .ring_indicate_output(ring_indicate_output));

`default_nettype wire

// File: cbsc_ctrl_tb.sv
// testbench of the system control low half register
`timescale 1ns/1ps
`default_nettype none

module cbsc_ctrl_tb
   import cbsc_pkg::*;
;
   typedef struct packed
   {
      logic        f;
      logic [3:0]  be;
      logic [31:0] w;
      logic [31:0] e0;
      logic [31:0] e1;
   } cbsc_row_t;
   logic          clk_sys, rst, hit, bdn, bup, lock, serr, allow, ring;
   logic          par, ckreq, ren, rreq, preq;
   logic [1:0]    acc, probe, is32, idle, crun, spd, zvf, smce, leg;
   logic [31:0]   rdata;
   cbsc_cfg_req_t req;
   cbsc_pwr_evt_t pwr;
   int            failures, checks_done;
   // write then expected readback of function 0 and function 1
   cbsc_row_t     rows [6] = '{
      '{1'b0, 4'hF, 32'h0034_FFF7, 32'h0034_D077, 32'h0004_1040},
      '{1'b1, 4'hF, 32'h0004_0000, 32'h0034_D077, 32'h0004_1000},
      '{1'b0, 4'h2, 32'h0000_0000, 32'h0034_1077, 32'h0004_1000},
      '{1'b0, 4'h4, 32'h0004_0000, 32'h0004_1077, 32'h0004_1000},
      '{1'b0, 4'h1, 32'h0000_0060, 32'h0004_1060, 32'h0004_1000},
      '{1'b0, 4'hF, 32'h0004_9060, 32'h0004_9060, 32'h0004_1000}};

   cbsc_ctrl #(.SOCKETS(2)) DUT (
      .clk_sys(clk_sys), .rst(rst), .cfg_req(req), .cfg_hit(hit),
      .cfg_rdata(rdata), .card_access(acc), .probe_running(probe),
      .pwr_evt(pwr), .card_is_32bit(is32), .card_idle(idle),
      .card_clk_running(crun), .card_parity_err(par),
      .clkrun_stop_req(ckreq), .ring_enable(ren), .ring_request(rreq),
      .pme_request(preq), .supply_protect_disable(spd),
      .reduced_video_addr_float(zvf), .read_burst_down_enable(bdn),
      .read_burst_up_enable(bup), .sm_clock_enable(smce),
      .ident_write_lock(lock), .syserr_from_card_parity(serr),
      .legacy_supply_select(leg), .clkrun_stop_allow(allow),
      .ring_indicate_output(ring));

   ////////////////////////////////////////////////////////////////////////
   // clock and watchdog
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial
   begin
      repeat (3000) @(posedge clk_sys);
      failures++;
      tally_and_finish();
   end

   ////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic op(input logic f, input logic w, input logic [3:0] be,
                     input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      req <= '{func: f, addr: a, rd: !w, wr: w, be: be, wdata: d};
      @(posedge clk_sys);
      req.rd <= 1'b0;
      req.wr <= 1'b0;
      #1;
   endtask : op
   task automatic pulse(input cbsc_pwr_evt_t e);
      @(posedge clk_sys);
      pwr <= e;
      @(posedge clk_sys);
      pwr <= '0;
   endtask : pulse
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      rst = 1'b1; req = '0; pwr = '0; acc = 2'h0; probe = 2'h0;
      is32 = 2'h3; idle = 2'h3; crun = 2'h0; par = 1'b1; ckreq = 1'b1;
      ren = 1'b1; rreq = 1'b1; preq = 1'b0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      op(0, 0, 4'hF, 8'h80, '0);
      chk(rdata, 32'h0004_9060);
      op(1, 0, 4'hF, 8'h80, '0);
      chk(rdata, 32'h0004_1040);
      chk({bdn, bup, lock, serr, allow, ring, smce, spd, zvf, leg},
          14'b10101100_000000);
      $display("test reset done");
      foreach (rows[i])
      begin
         op(rows[i].f, 1, rows[i].be, 8'h80, rows[i].w);
         op(0, 0, 4'hF, 8'h80, '0);
         chk(rdata, rows[i].e0);
         op(1, 0, 4'hF, 8'h83, '0);
         chk(rdata, rows[i].e1);
      end
      $display("test rows done");
      op(0, 1, 4'h1, 8'h80, 32'h72);
      chk({serr, allow, ring, smce}, 5'b10110);
      op(0, 1, 4'h1, 8'h80, 32'h61);
      chk(ring, preq);
      ren <= 1'b0;
      op(0, 1, 4'h1, 8'h80, 32'h60);
      chk({serr, allow, ring}, 3'b010);
      $display("test pins done");
      @(posedge clk_sys);
      acc <= 2'h2;
      @(posedge clk_sys);
      acc <= 2'h1;
      op(1, 0, 4'hF, 8'h80, '0);
      chk(rdata[13], 1'b1);
      acc <= 2'h0;
      op(1, 0, 4'hF, 8'h80, '0);
      chk(rdata[13], 1'b0);
      op(0, 0, 4'hF, 8'h80, '0);
      chk(rdata[13], 1'b1);
      probe <= 2'h1;
      op(0, 0, 4'hF, 8'h80, '0);
      chk({rdata[13], rdata[8]}, 2'b01);
      op(1, 0, 4'hF, 8'h80, '0);
      chk(rdata[8], 1'b0);
      probe <= 2'h0;
      $display("test status done");
      pulse(4'b1100);
      op(0, 0, 4'hF, 8'h80, '0);
      chk(rdata[11:9], 3'b100);
      pulse(4'b0010);
      op(0, 0, 4'hF, 8'h80, '0);
      chk(rdata[11:9], 3'b110);
      op(1, 0, 4'hF, 8'h80, '0);
      chk(rdata[11:9], 3'b000);
      pulse(4'b0001);
      op(0, 0, 4'hF, 8'h80, '0);
      chk(rdata[11:9], 3'b000);
      pulse(4'b1000);
      pulse(4'b0010);
      op(0, 0, 4'hF, 8'h80, '0);
      chk(rdata[11:9], 3'b101);
      pulse(4'b0001);
      op(0, 0, 4'hF, 8'h80, '0);
      chk(rdata, 32'h0004_9060);
      $display("test power done");
      op(0, 1, 4'hF, 8'h84, '0);
      op(0, 0, 4'hF, 8'h84, '0);
      chk(hit, 1'b0);
      chk(rdata, 32'h0004_9060);
      op(0, 1, 4'hF, 8'h80, 32'h0004_BFE0);
      op(0, 0, 4'hF, 8'h80, '0);
      chk(rdata, 32'h0004_9060);
      op(0, 1, 4'hF, 8'h80, 32'h0004_0000);
      @(posedge clk_sys);
      rst <= 1'b1;
      @(posedge clk_sys);
      rst <= 1'b0;
      op(0, 0, 4'hF, 8'h80, '0);
      chk(rdata, 32'h0004_9060);
      $display("test odd cases done");
      tally_and_finish();
   end
endmodule : cbsc_ctrl_tb

`default_nettype wire

// File: cbsc_pkg.sv
// package of constants and carriers for the card bridge system control low half
package cbsc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register location and field positions
   localparam logic [7:0] CBSC_OFFSET         = 8'h80;
   localparam int         CBSC_POS_PROT_DIS   = 21;
   localparam int         CBSC_POS_ZV_FLOAT   = 20;
   localparam int         CBSC_POS_RSVD_HI    = 16;
   localparam int         CBSC_POS_BURST_DN   = 15;
   localparam int         CBSC_POS_BURST_UP   = 14;
   localparam int         CBSC_POS_ACTIVITY   = 13;
   localparam int         CBSC_POS_RSVD_ONE   = 12;
   localparam int         CBSC_POS_STREAM     = 11;
   localparam int         CBSC_POS_DLY_UP     = 10;
   localparam int         CBSC_POS_DLY_DN     = 9;
   localparam int         CBSC_POS_PROBE      = 8;
   localparam int         CBSC_POS_CLK_GATE   = 6;
   localparam int         CBSC_POS_ID_LOCK    = 5;
   localparam int         CBSC_POS_PAR_SERR   = 4;
   localparam int         CBSC_POS_RSVD_LO    = 3;
   localparam int         CBSC_POS_LEG_SUPPLY = 2;
   localparam int         CBSC_POS_CLK_KEEP   = 1;
   localparam int         CBSC_POS_PIN_SEL    = 0;

   ////////////////////////////////////////////////////////////////////////
   // reset values of the writable fields (low half of 0044 9060h)
   localparam logic [3:0] CBSC_RST_RSVD_HI    = 4'h4;
   localparam logic       CBSC_RST_BURST_DN   = 1'b1;
   localparam logic       CBSC_RST_BURST_UP   = 1'b0;
   localparam logic       CBSC_RST_CLK_GATE   = 1'b1;
   localparam logic       CBSC_RST_ID_LOCK    = 1'b1;
   localparam logic       CBSC_RST_OTHER      = 1'b0;
   localparam logic       CBSC_RSVD_ONE_VAL   = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // power switch sequencing states
   typedef enum logic [1:0]
   {
      CBSC_PWR_IDLE   = 2'b00,
      CBSC_PWR_STREAM = 2'b01,
      CBSC_PWR_DELAY  = 2'b10
   } cbsc_pwr_state_t;

   // configuration access request
   typedef struct packed
   {
      logic        func;
      logic [7:0]  addr;
      logic        rd;
      logic        wr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } cbsc_cfg_req_t;

   // power switch engine events
   typedef struct packed
   {
      logic start;
      logic up;
      logic sent;
      logic delay_done;
   } cbsc_pwr_evt_t;

endpackage : cbsc_pkg

// File: cbsc_pwr_track.sv
// tracker of power switch stream and settling delay progress
`timescale 1ns/1ps
`default_nettype none

module cbsc_pwr_track
   import cbsc_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          rst,
   input  wire cbsc_pwr_evt_t evt,
   output logic               stream_busy,
   output logic               up_busy,
   output logic               down_busy
);

   cbsc_pwr_state_t state;
   cbsc_pwr_state_t next_state;
   logic            going_up;

   ////////////////////////////////////////////////////////////////////////
   // next state of the sequencer
   always_comb
   begin
      next_state = state;
      case (state)
         CBSC_PWR_IDLE:
            if (evt.start)
               next_state = CBSC_PWR_STREAM;
         CBSC_PWR_STREAM:
            if (evt.sent)
               next_state = CBSC_PWR_DELAY;
         CBSC_PWR_DELAY:
            if (evt.delay_done)
               next_state = CBSC_PWR_IDLE;
         default:
            next_state = CBSC_PWR_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         state <= CBSC_PWR_IDLE;
      else
         state <= next_state;
   end

   // direction captured when a change is requested
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         going_up <= 1'b0;
      else if (state == CBSC_PWR_IDLE && evt.start)
         going_up <= evt.up;
   end

   // status flags from flip-flops
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         stream_busy <= 1'b0;
         up_busy     <= 1'b0;
         down_busy   <= 1'b0;
      end
      else
      begin
         stream_busy <= (next_state != CBSC_PWR_IDLE);              // R9
         up_busy     <= (next_state == CBSC_PWR_DELAY) && going_up;  // R10
         down_busy   <= (next_state == CBSC_PWR_DELAY) && !going_up; // R11
      end
   end

endmodule : cbsc_pwr_track

`default_nettype wire
